// *** design/wake_rate_select.sv ***
// Wake rate configuration register with shadow window onto the software rate registers.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "wake_rate_defs.svh"
module wake_rate_select
   import wake_rate_pkg::*;
(
   input  wire logic        core_clk,           // Core clock, 250 MHz.
   input  wire logic        rst_n,              // Synchronous reset, active low.
   input  wire bus_req_t    bus_req,            // Register bus request.
   output logic [7:0]       rdata,              // Read data, valid the cycle after a read.
   output var wake_cfg_t    wake_cfg,           // Resolved wake sampling configuration.
   output logic [2:0]       sniff_power_mode,   // Power mode governing sniff rates.
   output logic             manual_rate_en,     // Software defined rate registers in use.
   output logic [3:0]       watch_bias_threshold,    // Sniff bias threshold nibble.
   output logic [3:0]       sampling_bias_threshold, // Wake bias threshold nibble.
   output logic [4:0]       sampling_freq_pick,      // Wake frequency pick.
   output logic [4:0]       watch_freq_pick,         // Sniff frequency pick.
   output logic [15:0]      sampling_clk_count,      // Wake rate clock count.
   output logic [15:0]      watch_clk_count          // Sniff rate clock count.
);
   // Stored registers, and the combinational next read data.
   logic [6:0]  wrc_ff;            // Rate register, bit seven is not kept.
   logic [7:0]  pm_ff;             // Power mode register copy.
   logic [7:0]  bias_ff;           // Threshold nibbles, sniff in the upper half.
   logic [4:0]  wfreq_ff;          // Wake frequency pick.
   logic [4:0]  sfreq_ff;          // Sniff frequency pick.
   logic [15:0] wcnt_ff;           // Wake clock count.
   logic [15:0] scnt_ff;           // Sniff clock count.
   logic [7:0]  rdata_ff;          // Registered read data.
   logic [7:0]  nxt_rdata;         // Read data for the next cycle.

   // Decoded fields and strobes.
   wire logic [3:0] rate_code  = wrc_ff[`WR_SEL_MSB:`WR_SEL_LSB];
   wire win_sel_t   win_sel    = win_sel_t'(wrc_ff[`WIN_SEL_MSB:`WIN_SEL_LSB]);
   wire logic [2:0] wake_pm    = pm_ff[`PM_WAKE_MSB:`PM_WAKE_LSB];
   wire logic       hit_wrc    = bus_req.addr == `WRC_ADDR;
   wire logic       hit_shadow = bus_req.addr == `SHADOW_DATA_ADDR;
   wire logic       hit_pm     = bus_req.addr == `POWER_MODE_ADDR;
   wire logic       wr_wrc     = bus_req.wr && hit_wrc;
   wire logic       wr_pm      = bus_req.wr && hit_pm;
   // Window writes land only when a shadow register is selected.
   wire logic       wr_win     = bus_req.wr && hit_shadow && (win_sel != WIN_OFF);

   // Map the power mode field onto the three documented classes.
   wire pm_class_t  pm_class = (wake_pm == `PM_ULP)  ? PM_CLASS_ULP :
                               (wake_pm == `PM_LP)   ? PM_CLASS_LP  :
                               (wake_pm == `PM_PREC) ? PM_CLASS_PREC : PM_CLASS_BAD;

   // Rate lookup in Hz; zero marks a combination that is unavailable.
   function automatic logic [10:0] rate_lookup(input logic [3:0] code, input pm_class_t cls);
      logic [10:0] r;
      r = 11'h000;
      unique case (cls)
         // Ultra low power has no rate for code five.
         PM_CLASS_ULP: begin
            case (code)
               4'h6: r = 11'd25;
               4'h7: r = 11'd50;
               4'h8: r = 11'd100;
               4'h9: r = 11'd190;
               4'ha: r = 11'd380;
               4'hb: r = 11'd750;
               4'hc: r = 11'd1100;
               4'hf: r = 11'd1300;
               default: r = 11'h000;
            endcase
         end
         // Low power stops at code eleven apart from the software rate.
         PM_CLASS_LP: begin
            case (code)
               4'h5: r = 11'd14;
               4'h6: r = 11'd28;
               4'h7: r = 11'd54;
               4'h8: r = 11'd105;
               4'h9: r = 11'd210;
               4'ha: r = 11'd400;
               4'hb: r = 11'd600;
               4'hf: r = 11'd750;
               default: r = 11'h000;
            endcase
         end
         // Precision trades the higher rates for lower noise and stops at code eight.
         PM_CLASS_PREC: begin
            case (code)
               4'h5: r = 11'd14;
               4'h6: r = 11'd28;
               4'h7: r = 11'd55;
               4'h8: r = 11'd80;
               4'hf: r = 11'd100;
               default: r = 11'h000;
            endcase
         end
         PM_CLASS_BAD: r = 11'h000;
      endcase
      return r;
   endfunction

   // Accepted code set; codes outside it never raise rate_valid.
   wire logic code_ok = ((rate_code >= `RATE_CODE_MIN) && (rate_code <= `RATE_CODE_MAX)) ||
                        (rate_code == `RATE_CODE_SW);
   wire logic [10:0] rate_hz = rate_lookup(rate_code, pm_class);

   // Rate and power mode registers; rate register bit seven is dropped so it always reads zero.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wrc_ff <= 7'(`WRC_RESET);
         pm_ff  <= `PM_RESET;
      end else begin
         if (wr_wrc) begin
            wrc_ff <= bus_req.wdata[6:0];
         end
         if (wr_pm) begin
            pm_ff <= bus_req.wdata;
         end
      end
   end

   // Shadow registers behind the shared data port, steered by the select field.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         bias_ff  <= `SHADOW_RESET;
         wfreq_ff <= 5'(`SHADOW_RESET);
         sfreq_ff <= 5'(`SHADOW_RESET);
         wcnt_ff  <= 16'(`SHADOW_RESET);
         scnt_ff  <= 16'(`SHADOW_RESET);
      end else if (wr_win) begin
         unique case (win_sel)
            WIN_OFF:     bias_ff <= bias_ff;
            WIN_BIAS:    bias_ff <= bus_req.wdata;
            WIN_WFREQ:   wfreq_ff <= bus_req.wdata[4:0];
            WIN_SFREQ:   sfreq_ff <= bus_req.wdata[4:0];
            WIN_WCNT_LO: wcnt_ff[7:0] <= bus_req.wdata;
            WIN_WCNT_HI: wcnt_ff[15:8] <= bus_req.wdata;
            WIN_SCNT_LO: scnt_ff[7:0] <= bus_req.wdata;
            WIN_SCNT_HI: scnt_ff[15:8] <= bus_req.wdata;
         endcase
      end
   end

   // Window read data; upper bits of the picks read as zero.
   wire logic [7:0] win_rdata =
      (win_sel == WIN_BIAS)    ? bias_ff :
      (win_sel == WIN_WFREQ)   ? {3'h0, wfreq_ff} :
      (win_sel == WIN_SFREQ)   ? {3'h0, sfreq_ff} :
      (win_sel == WIN_WCNT_LO) ? wcnt_ff[7:0] :
      (win_sel == WIN_WCNT_HI) ? wcnt_ff[15:8] :
      (win_sel == WIN_SCNT_LO) ? scnt_ff[7:0] :
      (win_sel == WIN_SCNT_HI) ? scnt_ff[15:8] : 8'h00;

   // Read multiplexer; unmapped addresses read zero.
   always_comb begin
      nxt_rdata = 8'h00;
      if (bus_req.rd) begin
         if (hit_wrc) begin
            nxt_rdata = {1'b0, wrc_ff};
         end else if (hit_pm) begin
            nxt_rdata = pm_ff;
         end else if (hit_shadow) begin
            nxt_rdata = win_rdata;
         end
      end
   end

   // Read data is held one cycle only, then drops to zero.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // Outputs.
   assign rdata                   = rdata_ff;
   // The resolved configuration is one bundle driven from a single place.
   assign wake_cfg = '{
      rate_code:  rate_code,
      power_mode: wake_pm,
      rate_valid: code_ok && (rate_hz != 11'h000),
      sw_rate:    rate_code == `RATE_CODE_SW,
      rate_hz:    rate_hz
   };
   assign sniff_power_mode        = pm_ff[`PM_SNIFF_MSB:`PM_SNIFF_LSB];
   assign manual_rate_en          = win_sel != WIN_OFF;
   assign watch_bias_threshold    = bias_ff[7:4];
   assign sampling_bias_threshold = bias_ff[3:0];
   assign sampling_freq_pick      = wfreq_ff;
   assign watch_freq_pick         = sfreq_ff;
   assign sampling_clk_count      = wcnt_ff;
   assign watch_clk_count         = scnt_ff;

   // Assertions.
   // Each check is masked while reset is low, so the first edge after release starts clean.

   // The rate register reads back its seven kept bits with bit seven clear.
   property p_rd_wrc;
      @(posedge core_clk) disable iff (!rst_n)
         bus_req.rd && hit_wrc |=> rdata == {1'b0, $past(wrc_ff)};
   endproperty
   a_rd_wrc: assert property (p_rd_wrc) else $error("rate register readback wrong");

   // A write to the rate register keeps the low seven data bits.
   property p_bit7;
      @(posedge core_clk) disable iff (!rst_n)
         wr_wrc |=> wrc_ff == $past(bus_req.wdata[6:0]);
   endproperty
   a_bit7: assert property (p_bit7) else $error("rate register write lost");

   // Low power code eleven resolves to six hundred samples per second.
   property p_lp_rate;
      @(posedge core_clk) disable iff (!rst_n)
         (wake_pm == 3'h0 && rate_code == 4'hb) |-> rate_hz == 11'd600;
   endproperty
   a_lp_rate: assert property (p_lp_rate) else $error("low power rate wrong");

   // Ultra low power has no rate for code five.
   property p_ulp_na;
      @(posedge core_clk) disable iff (!rst_n)
         (wake_pm == 3'h3 && rate_code == 4'h5) |-> !wake_cfg.rate_valid;
   endproperty
   a_ulp_na: assert property (p_ulp_na) else $error("unavailable rate marked valid");

   // Precision has no rate for codes nine to twelve.
   property p_prec_na;
      @(posedge core_clk) disable iff (!rst_n)
         (wake_pm == 3'h4 && rate_code inside {[4'h9:4'hc]}) |-> !wake_cfg.rate_valid;
   endproperty
   a_prec_na: assert property (p_prec_na) else $error("precision rate marked valid");

   // Codes zero, thirteen and fourteen, outside the accepted set, never resolve to a valid rate.
   property p_bad_code;
      @(posedge core_clk) disable iff (!rst_n)
         (rate_code inside {4'hd, 4'he, 4'h0}) |-> !wake_cfg.rate_valid;
   endproperty
   a_bad_code: assert property (p_bad_code) else $error("illegal code marked valid");

   // Sniff power mode follows bits six to four of the power mode register.
   property p_sniff_pm;
      @(posedge core_clk) disable iff (!rst_n)
         wr_pm |=> sniff_power_mode == $past(bus_req.wdata[6:4]);
   endproperty
   a_sniff_pm: assert property (p_sniff_pm) else $error("sniff power mode wrong");

   // Wake power mode follows bits two to zero of the power mode register.
   property p_wake_pm;
      @(posedge core_clk) disable iff (!rst_n)
         wr_pm |=> wake_cfg.power_mode == $past(bus_req.wdata[2:0]);
   endproperty
   a_wake_pm: assert property (p_wake_pm) else $error("wake power mode wrong");

   // Shadow writes with the window closed leave every shadow register alone.
   property p_off_nowrite;
      @(posedge core_clk) disable iff (!rst_n)
         (bus_req.wr && hit_shadow && win_sel == WIN_OFF) |=>
         $stable(wcnt_ff) && $stable(scnt_ff) && $stable(bias_ff) &&
         $stable(wfreq_ff) && $stable(sfreq_ff);
   endproperty
   a_off_nowrite: assert property (p_off_nowrite) else $error("window off write leaked");

   // Reads with the window closed return zero.
   property p_off_read;
      @(posedge core_clk) disable iff (!rst_n)
         (bus_req.rd && hit_shadow && win_sel == WIN_OFF) |=> rdata == 8'h00;
   endproperty
   a_off_read: assert property (p_off_read) else $error("window off read not zero");

   // Both picks read back with their three upper bits clear.
   property p_pick_zero;
      @(posedge core_clk) disable iff (!rst_n)
         (bus_req.rd && hit_shadow && win_sel inside {WIN_WFREQ, WIN_SFREQ}) |=> rdata[7:5] == 3'h0;
   endproperty
   a_pick_zero: assert property (p_pick_zero) else $error("pick upper bits not zero");

   // A low count byte lands in the low half and leaves the high half.
   property p_wcnt_lo;
      @(posedge core_clk) disable iff (!rst_n)
         (wr_win && win_sel == WIN_WCNT_LO) |=> sampling_clk_count == {$past(wcnt_ff[15:8]), $past(bus_req.wdata)};
   endproperty
   a_wcnt_lo: assert property (p_wcnt_lo) else $error("wake count low byte wrong");

   // A high count byte lands in the upper half of the sniff count.
   property p_cnt_hi;
      @(posedge core_clk) disable iff (!rst_n)
         (wr_win && win_sel == WIN_SCNT_HI) |=> watch_clk_count[15:8] == $past(bus_req.wdata);
   endproperty
   a_cnt_hi: assert property (p_cnt_hi) else $error("sniff count high byte wrong");

   // Manual rate mode follows the select field written to the rate register.
   property p_win_sel;
      @(posedge core_clk) disable iff (!rst_n)
         wr_wrc |=> manual_rate_en == ($past(bus_req.wdata[6:4]) != 3'h0);
   endproperty
   a_win_sel: assert property (p_win_sel) else $error("window select wrong");

   // Main scenarios that the bench must reach.
   c_sw_rate: cover property (@(posedge core_clk) disable iff (!rst_n)
      wake_cfg.sw_rate);
   c_win_rd: cover property (@(posedge core_clk) disable iff (!rst_n)
      bus_req.rd && hit_shadow && manual_rate_en);
   c_valid: cover property (@(posedge core_clk) disable iff (!rst_n)
      wake_cfg.rate_valid && pm_class == PM_CLASS_PREC);
   c_off_write: cover property (@(posedge core_clk) disable iff (!rst_n)
      bus_req.wr && hit_shadow && !manual_rate_en);
endmodule
`default_nettype wire

// *** design/wake_rate_defs.svh ***
// Offsets, field positions, reset values and codes for the wake rate select block.
`ifndef WAKE_RATE_DEFS_SVH
`define WAKE_RATE_DEFS_SVH
`define WRC_ADDR          8'h11
`define SHADOW_DATA_ADDR  8'h29
`define POWER_MODE_ADDR   8'h1c
`define WRC_RESET         8'h00
`define SHADOW_RESET      8'h00
`define PM_RESET          8'h00
`define WR_SEL_LSB        0
`define WR_SEL_MSB        3
`define WIN_SEL_LSB       4
`define WIN_SEL_MSB       6
`define UNUSED_BIT_POS    7
`define PM_WAKE_LSB       0
`define PM_WAKE_MSB       2
`define PM_SNIFF_LSB      4
`define PM_SNIFF_MSB      6
`define PM_ULP            3'h3
`define PM_LP             3'h0
`define PM_PREC           3'h4
`define RATE_CODE_MIN     4'h5
`define RATE_CODE_MAX     4'hc
`define RATE_CODE_SW      4'hf
`endif

// *** design/wake_rate_pkg.sv ***
// Types shared by the wake rate select block.
`default_nettype none
package wake_rate_pkg;
   // Shadow window address decoded from the select field.
   typedef enum logic [2:0] {
      WIN_OFF, WIN_BIAS, WIN_WFREQ, WIN_SFREQ,
      WIN_WCNT_LO, WIN_WCNT_HI, WIN_SCNT_LO, WIN_SCNT_HI
   } win_sel_t;
   // Power mode class used to look up an output rate.
   typedef enum logic [1:0] {PM_CLASS_ULP, PM_CLASS_LP, PM_CLASS_PREC, PM_CLASS_BAD} pm_class_t;
   // Register bus request bundle.
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } bus_req_t;
   // Resolved wake sampling configuration handed to the sample sequencer.
   typedef struct packed {
      logic [3:0]  rate_code;
      logic [2:0]  power_mode;
      logic        rate_valid;
      logic        sw_rate;
      logic [10:0] rate_hz;
   } wake_cfg_t;
endpackage
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking testbench for the wake rate select register block.
`timescale 1ns/100ps
`default_nettype none
module tb;
   import wake_rate_pkg::*;
   logic        core_clk;     // Core clock, 4 ns period.
   logic        rst_n;        // Synchronous reset, active low.
   bus_req_t    bus_req;      // Register bus request.
   logic [7:0]  rdata;        // Read data.
   wake_cfg_t   wake_cfg;     // Resolved wake configuration.
   logic [2:0]  sniff_pm;     // Sniff power mode.
   logic        man_en;       // Manual rate mode flag.
   logic [3:0]  wbt, sbt;     // Threshold nibbles.
   logic [4:0]  sfp, wfp;     // Frequency picks.
   logic [15:0] scc, wcc;     // Clock counts.
   int          mismatches;   // Count of failed comparisons.
   int          n_tests;      // Count of comparisons.
   logic [15:0] shadow_seen;  // Shadow output picked by the window select.
   logic [10:0] lp_hz [7];    // Low power rates for codes five to eleven.

   wake_rate_select uut (.core_clk(core_clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
      .wake_cfg(wake_cfg), .sniff_power_mode(sniff_pm), .manual_rate_en(man_en),
      .watch_bias_threshold(wbt), .sampling_bias_threshold(sbt), .sampling_freq_pick(sfp),
      .watch_freq_pick(wfp), .sampling_clk_count(scc), .watch_clk_count(wcc));

   // Free running clock; the half period matches 250 MHz.
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // Compares one value; an unknown bit seen against a known expected bit fails because of case equality.
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One write cycle; the strobe drops at the next edge, so no task re-enters that edge.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      bus_req <= '0;
   endtask

   // One read cycle; data stand only in the following cycle, so it is sampled there.
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      bus_req <= '0;
      #1;
      chk(what, {8'h00, exp}, {8'h00, rdata});
   endtask

   // Prints counts and the verdict, then ends the run.
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Reset values of the rate and power mode registers, the rate valid flag and an unmapped read.
   task automatic t_reset();
      rd_chk("rate reg reset", 8'h11, 8'h00);
      rd_chk("power reg reset", 8'h1c, 8'h00);
      chk("rate valid reset", 16'h0000, {15'h0, wake_cfg.rate_valid});
      rd_chk("unmapped read", 8'h30, 8'h00);
   endtask

   // Selector field, dropped top bit and the two power mode groups.
   task automatic t_fields();
      wr(8'h11, 8'h87);
      rd_chk("top bit dropped", 8'h11, 8'h07);
      @(posedge core_clk);
      #1;
      chk("read data one cycle", 16'h0000, {8'h00, rdata});
      chk("rate code", 16'h0007, {12'h0, wake_cfg.rate_code});
      wr(8'h1c, 8'h43);
      #1;
      chk("wake power mode", 16'h0003, {13'h0, wake_cfg.power_mode});
      chk("sniff power mode", 16'h0004, {13'h0, sniff_pm});
      chk("ulp code 7 rate", 16'd50, {5'h0, wake_cfg.rate_hz});
      rd_chk("power reg readback", 8'h1c, 8'h43);
   endtask

   // Rate lookup across codes and power modes, including unavailable pairs.
   task automatic t_rates();
      lp_hz = '{11'd14, 11'd28, 11'd54, 11'd105, 11'd210, 11'd400, 11'd600};
      wr(8'h1c, 8'h00);
      for (int i = 0; i < 7; i++) begin
         wr(8'h11, 8'h05 + 8'(i));
         #1;
         chk("lp rate", {5'h0, lp_hz[i]}, {5'h0, wake_cfg.rate_hz});
         chk("lp valid", 16'h0001, {15'h0, wake_cfg.rate_valid});
      end
      wr(8'h11, 8'h0c);
      #1;
      chk("lp code c invalid", 16'h0000, {15'h0, wake_cfg.rate_valid});
      wr(8'h11, 8'h0f);
      #1;
      chk("sw rate flag", 16'h0001, {15'h0, wake_cfg.sw_rate});
      chk("lp code f rate", 16'd750, {5'h0, wake_cfg.rate_hz});
      wr(8'h1c, 8'h04);
      #1;
      chk("prec code f rate", 16'd100, {5'h0, wake_cfg.rate_hz});
      wr(8'h11, 8'h09);
      #1;
      chk("prec code 9 invalid", 16'h0000, {15'h0, wake_cfg.rate_valid});
      wr(8'h1c, 8'h03);
      wr(8'h11, 8'h05);
      #1;
      chk("ulp code 5 invalid", 16'h0000, {15'h0, wake_cfg.rate_valid});
      wr(8'h11, 8'h0c);
      #1;
      chk("ulp code c rate", 16'd1100, {5'h0, wake_cfg.rate_hz});
      wr(8'h1c, 8'h01);
      #1;
      chk("bad power mode", 16'h0000, {15'h0, wake_cfg.rate_valid});
   endtask

   // Shadow window: each select reaches its own register, select zero reaches none.
   task automatic t_window();
      logic [7:0] d;
      logic [7:0] e;
      wr(8'h11, 8'h05);
      wr(8'h29, 8'h5a);
      rd_chk("window off read", 8'h29, 8'h00);
      chk("manual off", 16'h0000, {15'h0, man_en});
      chk("off write ignored", 16'h0000, scc | wcc | {8'h00, wbt, sbt});
      for (int s = 1; s < 8; s++) begin
         d = 8'hf0 ^ 8'(s * 8'h13);
         e = (s == 2 || s == 3) ? {3'h0, d[4:0]} : d;
         wr(8'h11, {1'b0, 3'(s), 4'h5});
         wr(8'h29, d);
         rd_chk("window read", 8'h29, e);
         case (s)
            1: shadow_seen = {8'h00, wbt, sbt};
            2: shadow_seen = {11'h0, sfp};
            3: shadow_seen = {11'h0, wfp};
            4: shadow_seen = {8'h00, scc[7:0]};
            5: shadow_seen = {8'h00, scc[15:8]};
            6: shadow_seen = {8'h00, wcc[7:0]};
            default: shadow_seen = {8'h00, wcc[15:8]};
         endcase
         chk("shadow output", {8'h00, e}, shadow_seen);
         chk("manual on", 16'h0001, {15'h0, man_en});
      end
      // Selects four and five wrote 8'hf0 ^ 8'h4c and 8'hf0 ^ 8'h5f.
      chk("wake count", 16'hafbc, scc);
      chk("sniff count", 16'h7582, wcc);
      wr(8'h11, 8'h05);
      wr(8'h29, 8'h00);
      #1;
      chk("closed window keeps count", 16'hafbc, scc);
      chk("manual off again", 16'h0000, {15'h0, man_en});
   endtask

   // Reset in mid run returns every register to zero after state was written.
   task automatic t_mid_reset();
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      rd_chk("rate reg after reset", 8'h11, 8'h00);
      rd_chk("power reg after reset", 8'h1c, 8'h00);
      chk("counts after reset", 16'h0000, scc | wcc);
      chk("picks after reset", 16'h0000, {6'h00, sfp, wfp});
      chk("bias after reset", 16'h0000, {8'h00, wbt, sbt});
      chk("manual after reset", 16'h0000, {15'h0, man_en});
   endtask

   // Watchdog: the tests need well under a thousand cycles.
   initial begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      complete_run();
   end

   // Main sequence: reset for 16 cycles, then each scenario in turn.
   initial begin
      mismatches = 0;
      n_tests = 0;
      rst_n = 1'b0;
      bus_req = '0;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      t_reset();
      t_fields();
      t_rates();
      t_window();
      t_mid_reset();
      complete_run();
   end
endmodule
`default_nettype wire
